// [src/trace_ctl_pkg.sv]
// constants and register map of the trace stall, timestamp and sync control
package trace_ctl_pkg;
	localparam int ADDR_W = 12;

	// register byte offsets
	localparam logic [11:0] MAIN_CFG_OFS = 12'h000;
	localparam logic [11:0] STALL_CTL_OFS = 12'h004;
	localparam logic [11:0] TS_CTL_OFS = 12'h008;
	localparam logic [11:0] SYNC_PER_OFS = 12'h00C;
	localparam logic [11:0] TRACE_EN_OFS = 12'h010;

	// field positions
	localparam int STALL_PERMIT_BIT = 8;
	localparam int LEVEL_MSB = 3;
	localparam int LEVEL_LSB = 2;
	localparam int TS_EVENT_MSB = 7;
	localparam int GTS_EN_BIT = 11;
	localparam int TRACE_EN_BIT = 0;
	localparam int PERIOD_W = 5;

	// writable masks
	localparam logic [31:0] MAIN_CFG_WMASK = 32'h0000_1F18;
	localparam logic [31:0] STALL_CTL_WMASK = 32'h0000_010C;
	localparam logic [31:0] TS_CTL_WMASK = 32'h0000_00FF;

	// reset and fixed values
	localparam logic [31:0] MAIN_CFG_RST = 32'h0000_0001;
	localparam logic [31:0] STALL_CTL_RST = 32'h0000_0000;
	localparam logic [31:0] TS_CTL_RST = 32'h0000_0000;
	localparam logic TRACE_EN_RST = 1'b0;
	localparam logic [PERIOD_W-1:0] SYNC_PERIOD_VAL = 5'h0A;

	// stall thresholds in eighths of the fifo depth, per level index
	localparam int THR_EIGHTHS_TOP = 7;
	localparam int THR_EIGHTHS_STEP = 2;
endpackage : trace_ctl_pkg

// [src/sync_req_if.sv]
// carrier between the control block and its sync byte counter
`timescale 1ns/10ps
`default_nettype none
interface sync_req_if #(
	parameter int NUM_W = 3
);
	logic bytes_valid;
	logic [NUM_W-1:0] bytes_num;
	logic [4:0] period_log2;
	logic run;
	logic req;

	modport ctl (
		output bytes_valid,
		output bytes_num,
		output period_log2,
		output run,
		input req
	);
	modport cnt (
		input bytes_valid,
		input bytes_num,
		input period_log2,
		input run,
		output req
	);
endinterface : sync_req_if
`default_nettype wire

// [src/sync_period_counter.sv]
// byte counter that raises a sync request once per period
`timescale 1ns/10ps
`default_nettype none
module sync_period_counter
	import trace_ctl_pkg::*;
#(
	parameter int CNT_W = 32,
	parameter int NUM_W = 3
) (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// link to the control block
	sync_req_if.cnt sif
);
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic req_q;
	logic req_d;
	logic [CNT_W:0] sum;
	logic [CNT_W:0] period;

	assign sif.req = req_q;

	// period is a power of two; bytes per beat must stay below it
	always_comb begin
		period = {{CNT_W{1'b0}}, 1'b1} << sif.period_log2;
		sum = {1'b0, cnt_q} + {{(CNT_W+1-NUM_W){1'b0}}, sif.bytes_num};
		cnt_d = cnt_q;
		req_d = 1'b0;
		if (!sif.run) begin
			cnt_d = '0;
		end else if (sif.bytes_valid) begin
			if (sum >= period) begin
				cnt_d = CNT_W'(sum - period);
				req_d = 1'b1;
			end else begin
				cnt_d = sum[CNT_W-1:0];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			cnt_q <= '0;
			req_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			req_q <= req_d;
		end
	end

	a_req_has_cause: assert property (@(posedge mclk) disable iff (!resetn)
		req_q |-> $past(sif.run && sif.bytes_valid))
		else $error("sync request without counted bytes");
	a_cnt_below_period: assert property (@(posedge mclk) disable iff (!resetn)
		sif.run |-> ({1'b0, cnt_q} < period))
		else $error("sync byte count reached period without request");
endmodule : sync_period_counter
`default_nettype wire

// [src/trace_stall_timestamp_sync_ctl.sv]
// stall, global timestamp and sync control with its apb register bank
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module trace_stall_timestamp_sync_ctl
	import trace_ctl_pkg::*;
#(
	parameter int FIFO_DEPTH = 64,
	parameter int LVL_W = $clog2(FIFO_DEPTH) + 1,
	parameter int NUM_EVENTS = 256,
	parameter int NUM_W = 3,
	parameter int CNT_W = 32
) (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// instruction trace fifo and byte stream
	input wire logic [LVL_W-1:0] fifo_level,
	input wire logic ibytes_valid,
	input wire logic [NUM_W-1:0] ibytes_num,
	// trace events
	input wire logic [NUM_EVENTS-1:0] trace_events,
	// to the processor and the packet encoder
	output logic stall_req,
	output logic ts_insert,
	output logic sync_req,
	output logic trace_suppress
);
	// register state
	logic [31:0] main_cfg_q;
	logic [31:0] main_cfg_d;
	logic [31:0] stall_ctl_q;
	logic [31:0] stall_ctl_d;
	logic [31:0] ts_ctl_q;
	logic [31:0] ts_ctl_d;
	logic trace_en_q;
	logic trace_en_d;

	// apb read path
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic err_q;
	logic err_d;
	logic setup;
	logic wr_strobe;

	// trace side outputs
	logic stall_q;
	logic stall_d;
	logic ts_q;
	logic ts_d;
	logic sync_q;
	logic sync_d;
	logic supp_q;
	logic supp_d;
	logic [1:0] level_idx;
	logic [LVL_W-1:0] thr;
	logic event_hit;

	sync_req_if #(.NUM_W(NUM_W)) sif ();

	// fill above which stalling starts, for one level index
	function automatic logic [LVL_W-1:0] stall_threshold(
		input logic [1:0] idx
	);
		int eighths;
		eighths = THR_EIGHTHS_TOP - THR_EIGHTHS_STEP * int'(idx);
		return LVL_W'((FIFO_DEPTH * eighths) / 8);
	endfunction : stall_threshold

	// zero wait states: data is latched in setup, returned in access
	assign setup = psel && !penable;
	assign wr_strobe = psel && penable && pwrite;
	assign pready = 1'b1;
	assign prdata = prdata_q;
	assign pslverr = psel && penable && err_q;

	always_comb begin
		prdata_d = prdata_q;
		err_d = err_q;
		if (setup) begin
			err_d = 1'b0;
			if (paddr == MAIN_CFG_OFS) begin
				prdata_d = main_cfg_q;
			end else if (paddr == STALL_CTL_OFS) begin
				prdata_d = stall_ctl_q;
			end else if (paddr == TS_CTL_OFS) begin
				prdata_d = ts_ctl_q;
			end else if (paddr == SYNC_PER_OFS) begin
				prdata_d = {{(32-PERIOD_W){1'b0}}, SYNC_PERIOD_VAL};
			end else if (paddr == TRACE_EN_OFS) begin
				prdata_d = {31'h0000_0000, trace_en_q};
			end else begin
				prdata_d = 32'h0000_0000;
				err_d = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			prdata_q <= 32'h0000_0000;
			err_q <= 1'b0;
		end else begin
			prdata_q <= prdata_d;
			err_q <= err_d;
		end
	end

	// register writes; sync period has no write path at all
	always_comb begin
		main_cfg_d = main_cfg_q;
		stall_ctl_d = stall_ctl_q;
		ts_ctl_d = ts_ctl_q;
		trace_en_d = trace_en_q;
		if (wr_strobe) begin
			if (paddr == MAIN_CFG_OFS) begin
				main_cfg_d = (pwdata & MAIN_CFG_WMASK) | MAIN_CFG_RST;
			end else if (paddr == STALL_CTL_OFS && !trace_en_q) begin
				stall_ctl_d = pwdata & STALL_CTL_WMASK;
			end else if (paddr == TS_CTL_OFS && !trace_en_q) begin
				ts_ctl_d = pwdata & TS_CTL_WMASK;
			end else if (paddr == TRACE_EN_OFS) begin
				trace_en_d = pwdata[TRACE_EN_BIT];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			main_cfg_q <= MAIN_CFG_RST;
			stall_ctl_q <= STALL_CTL_RST;
			ts_ctl_q <= TS_CTL_RST;
			trace_en_q <= TRACE_EN_RST;
		end else begin
			main_cfg_q <= main_cfg_d;
			stall_ctl_q <= stall_ctl_d;
			ts_ctl_q <= ts_ctl_d;
			trace_en_q <= trace_en_d;
		end
	end

	// sync byte counting runs only while trace is enabled
	assign sif.bytes_valid = ibytes_valid;
	assign sif.bytes_num = ibytes_num;
	assign sif.period_log2 = SYNC_PERIOD_VAL;
	assign sif.run = trace_en_q;

	sync_period_counter #(
		.CNT_W(CNT_W),
		.NUM_W(NUM_W)
	) u_sync_cnt (
		.mclk(mclk),
		.resetn(resetn),
		.sif(sif)
	);

	// stall, timestamp and sync outputs
	assign level_idx = stall_ctl_q[LEVEL_MSB:LEVEL_LSB];
	assign thr = stall_threshold(level_idx);
	assign event_hit = trace_events[ts_ctl_q[TS_EVENT_MSB:0]];

	always_comb begin
		stall_d = trace_en_q && stall_ctl_q[STALL_PERMIT_BIT]
			&& (fifo_level > thr);
		// drop optional packets only while stalling at a non-zero level
		supp_d = stall_q && (level_idx != 2'b00);
		ts_d = trace_en_q && main_cfg_q[GTS_EN_BIT] && event_hit
			&& !supp_q;
		sync_d = sif.req && !supp_q;
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			stall_q <= 1'b0;
			supp_q <= 1'b0;
			ts_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			stall_q <= stall_d;
			supp_q <= supp_d;
			ts_q <= ts_d;
			sync_q <= sync_d;
		end
	end

	assign stall_req = stall_q;
	assign trace_suppress = supp_q;
	assign ts_insert = ts_q;
	assign sync_req = sync_q;

	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	sequence s_sync_setup;
		psel && !penable && !pwrite && paddr == SYNC_PER_OFS;
	endsequence

	sequence s_stall_write_locked;
		trace_en_q && wr_strobe && paddr == STALL_CTL_OFS;
	endsequence

	sequence s_ts_write_locked;
		trace_en_q && wr_strobe && paddr == TS_CTL_OFS;
	endsequence

	a_stall_on_fill: assert property (
		trace_en_q && stall_ctl_q[STALL_PERMIT_BIT] && fifo_level > thr
		|=> stall_req)
		else $error("stall not raised above threshold");
	a_stall_never_off: assert property (
		!stall_ctl_q[STALL_PERMIT_BIT] |=> !stall_req)
		else $error("stall raised while not permitted");
	a_level_max_thr: assert property (
		trace_en_q && stall_ctl_q[STALL_PERMIT_BIT] && level_idx == 2'b11
		&& fifo_level > LVL_W'(FIFO_DEPTH / 8) |=> stall_req)
		else $error("maximum level threshold wrong");
	a_level_low_zero: assert property (
		stall_ctl_q[LEVEL_LSB-1:0] == 2'b00)
		else $error("level low bits not zero");
	a_suppress_level: assert property (
		trace_suppress |-> $past(level_idx) != 2'b00 && $past(stall_req))
		else $error("suppression without raised level");
	a_stall_ctl_lock: assert property (
		s_stall_write_locked |=> $stable(stall_ctl_q))
		else $error("stall control written while enabled");
	a_ts_ctl_lock: assert property (
		s_ts_write_locked |=> $stable(ts_ctl_q))
		else $error("timestamp control written while enabled");
	a_ts_on_event: assert property (
		trace_en_q && main_cfg_q[GTS_EN_BIT] && event_hit && !supp_q
		|=> ts_insert)
		else $error("selected event gave no timestamp");
	a_ts_gated_off: assert property (
		!main_cfg_q[GTS_EN_BIT] |=> !ts_insert)
		else $error("timestamp while global timestamps disabled");
	a_sync_read_fixed: assert property (
		s_sync_setup |=> prdata == 32'h0000_000A && !pslverr)
		else $error("sync period read wrong");
	a_sync_follows_req: assert property (
		sif.req && !supp_q |=> sync_req)
		else $error("sync request lost");
endmodule : trace_stall_timestamp_sync_ctl
`default_nettype wire

// [verification/core_model.sv]
// processor core model: fills the trace fifo unless stalled
`timescale 1ns/10ps
`default_nettype none
module core_model #(
	parameter int LVL_W = 7
) (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// stall request and fill control
	input wire logic stall_req,
	input wire logic [LVL_W-1:0] target,
	input wire logic clr,
	// fifo fill seen by the block, and its peak for the bench
	output logic [LVL_W-1:0] fifo_level,
	output logic [LVL_W-1:0] peak
);
	// a stalled core issues nothing, so the fifo can only drain
	always @(posedge mclk) begin
		if (!resetn) begin
			fifo_level <= '0;
		end else if (stall_req || fifo_level > target) begin
			fifo_level <= fifo_level - 1'b1;
		end else if (fifo_level < target) begin
			fifo_level <= fifo_level + 1'b1;
		end
		if (!resetn || clr) begin
			peak <= '0;
		end else if (fifo_level > peak) begin
			peak <= fifo_level;
		end
	end
endmodule : core_model
`default_nettype wire

// [verification/tb.sv]
// self-checking bench of the trace stall, timestamp and sync control
`timescale 1ns/10ps
`default_nettype none
module tb
	import trace_ctl_pkg::*;
;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, stall_req, ts_insert, sync_req, trace_suppress;
	logic [6:0] fifo_level, peak;
	logic [6:0] target = 7'h0;
	logic clr = 1'b0;
	logic ib_valid = 1'b0;
	logic [2:0] ib_num = 3'h0;
	logic [255:0] events = '0;
	int n_errors = 0;
	int checked = 0;
	int cycles = 0;
	int n_ts = 0;
	int n_sync = 0;
	int n_supp = 0;
	logic [31:0] rd;
	logic err;

	always #10 mclk = ~mclk;

	trace_stall_timestamp_sync_ctl #(
		.FIFO_DEPTH(64)
	) i_trace_stall_timestamp_sync_ctl (
		.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .fifo_level(fifo_level),
		.ibytes_valid(ib_valid), .ibytes_num(ib_num), .trace_events(events),
		.stall_req(stall_req), .ts_insert(ts_insert), .sync_req(sync_req),
		.trace_suppress(trace_suppress)
	);
	core_model #(.LVL_W(7)) i_core_model (
		.mclk(mclk), .resetn(resetn), .stall_req(stall_req), .target(target),
		.clr(clr), .fifo_level(fifo_level), .peak(peak)
	);

	// pulse counters; a hang is cut short here as well
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		n_ts <= clr ? 0 : n_ts + int'(ts_insert);
		n_sync <= clr ? 0 : n_sync + int'(sync_req);
		n_supp <= clr ? 0 : n_supp + int'(trace_suppress);
		if (cycles == 20000) begin
			n_errors++;
			report_and_stop;
		end
	end

	task report_and_stop;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// request held until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		// a slave that never answers is a mismatch, not a silent pass
		if (n >= 20) begin
			n_errors++;
			$display("unexpected pready: expected 1 seen %b", pready);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rdchk(input string what, input logic [11:0] a, input logic [31:0] exp,
			input logic exp_err);
		apb(1'b0, a, 32'h0);
		chk(what, exp, rd);
		chk("pslverr", 32'(exp_err), 32'(err));
	endtask : rdchk

	task pulse_clr;
		clr <= 1'b1;
		@(posedge mclk);
		clr <= 1'b0;
	endtask : pulse_clr

	task t_regs;
		rdchk("main cfg", MAIN_CFG_OFS, MAIN_CFG_RST, 1'b0);
		rdchk("stall ctl", STALL_CTL_OFS, 32'h0, 1'b0);
		wr(SYNC_PER_OFS, 32'hFFFF_FFFF);
		rdchk("sync period", SYNC_PER_OFS, 32'hA, 1'b0);
		wr(STALL_CTL_OFS, 32'hFFFF_FFFF);
		rdchk("stall ctl", STALL_CTL_OFS, 32'h10C, 1'b0);
		rdchk("unmapped", 12'h100, 32'h0, 1'b1);
		wr(TS_CTL_OFS, 32'hA5);
		wr(TRACE_EN_OFS, 32'h1);
		wr(STALL_CTL_OFS, 32'h0);
		wr(TS_CTL_OFS, 32'h0);
		rdchk("stall ctl", STALL_CTL_OFS, 32'h10C, 1'b0);
		rdchk("ts ctl", TS_CTL_OFS, 32'hA5, 1'b0);
	endtask : t_regs

	// the fifo overshoots the threshold by two: one for the lag of the block
	task t_stall;
		for (int i = 0; i < 5; i++) begin
			wr(TRACE_EN_OFS, 32'h0);
			wr(STALL_CTL_OFS, i < 4 ? 32'h100 | (32'(i) << 2) : 32'hC);
			pulse_clr;
			target <= 7'h3F;
			wr(TRACE_EN_OFS, 32'h1);
			repeat (120) @(posedge mclk);
			chk("peak", i < 4 ? 64 * (7 - 2 * i) / 8 + 2 : 63, 32'(peak));
			chk("suppress", 32'(i > 0 && i < 4), 32'(n_supp > 0));
			target <= 7'h0;
			repeat (80) @(posedge mclk);
		end
	endtask : t_stall

	task t_ts;
		wr(TRACE_EN_OFS, 32'h0);
		wr(STALL_CTL_OFS, 32'h0);
		for (int g = 0; g < 2; g++) begin
			wr(TRACE_EN_OFS, 32'h0);
			wr(MAIN_CFG_OFS, 32'(g) << GTS_EN_BIT);
			wr(TS_CTL_OFS, 32'h5C);
			wr(TRACE_EN_OFS, 32'h1);
			pulse_clr;
			events <= 256'(1) << 93;
			@(posedge mclk);
			events <= 256'(1) << 92;
			repeat (3) @(posedge mclk);
			events <= '0;
			repeat (3) @(posedge mclk);
			chk("ts pulses", 32'(3 * g), 32'(n_ts));
		end
	endtask : t_ts

	// 1024 bytes per request: 255 beats of four stay short of it
	task t_sync;
		wr(TRACE_EN_OFS, 32'h0);
		wr(TRACE_EN_OFS, 32'h1);
		pulse_clr;
		ib_num <= 3'h4;
		ib_valid <= 1'b1;
		repeat (255) @(posedge mclk);
		ib_valid <= 1'b0;
		repeat (4) @(posedge mclk);
		chk("sync early", 32'h0, 32'(n_sync));
		ib_valid <= 1'b1;
		@(posedge mclk);
		ib_valid <= 1'b0;
		repeat (3) @(posedge mclk);
		chk("sync pulses", 32'h1, 32'(n_sync));
	endtask : t_sync

	initial begin
		repeat (10) @(posedge mclk);
		resetn <= 1'b1;
		t_regs;
		t_stall;
		t_ts;
		t_sync;
		report_and_stop;
	end
endmodule : tb
`default_nettype wire
